// *** pkg/bsp_pkg.sv ***
// Constants for the brake sequencer with PWM brake drive.
// Assumes a 100 MHz system clock and an APB slave with 32-bit data.
package bsp_pkg;
  localparam logic [11:0] ADDR_SUBMODE   = 12'h000;
  localparam logic [11:0] ADDR_OUTWORD   = 12'h004;
  localparam logic [11:0] ADDR_DELAY1    = 12'h008;
  localparam logic [11:0] ADDR_DELAY2    = 12'h00c;
  localparam logic [11:0] ADDR_DELAY3    = 12'h010;
  localparam logic [11:0] ADDR_DELAY4    = 12'h014;
  localparam logic [11:0] ADDR_PWMFREQ   = 12'h018;
  localparam logic [11:0] ADDR_PWMDUTY   = 12'h01c;
  localparam logic [11:0] ADDR_CONTROL   = 12'h020;
  localparam logic [11:0] ADDR_STATUS    = 12'h024;
  localparam int          SUBMODE_BRAKE  = 2;
  localparam int          OUT_BRAKE_BIT  = 0;
  localparam logic [31:0] FREQ_MAX       = 32'h0000_4e20;
  localparam logic [6:0]  DUTY_MIN       = 7'h02;
  localparam logic [6:0]  DUTY_FULL      = 7'h64;
  localparam logic [31:0] FREQ_RESET     = 32'h0000_03e8;
  localparam logic [6:0]  DUTY_RESET     = 7'h64;
  localparam int          CLK_HZ         = 100000000;
  localparam int          MS_CYCLES      = CLK_HZ / 1000;
  typedef enum logic [2:0] {
    ST_OFF, ST_ON_WAIT3, ST_ON_WAIT4, ST_ENABLED, ST_OFF_WAIT1, ST_OFF_WAIT2
  } bsp_state_type;
endpackage

// *** hw/bsp_pwm_gen.sv ***
// Brake PWM generator: period and high time in system clock cycles.
// Assumes settings were checked before they reach it.
`timescale 1ns/1ps
`default_nettype none
module bsp_pwm_gen (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Settings.
  input  wire logic        enable,
  input  wire logic [31:0] freqHz,
  input  wire logic [6:0]  dutyPct,
  // Waveform.
  output var  logic        pwmOut
);
  logic [31:0] periodCyc;
  logic [31:0] highCyc;
  logic [31:0] cnt_r;
  // The divider is combinational; it is only re-evaluated on setting change.
  assign periodCyc = 32'(bsp_pkg::CLK_HZ) / freqHz;
  assign highCyc   = 32'((64'(periodCyc) * 64'(dutyPct)) / 64'd100);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 32'h0;
    end else if (!enable || cnt_r + 32'h1 >= periodCyc) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pwmOut <= 1'b0;
    end else if (!enable) begin
      pwmOut <= 1'b0;
    end else if (dutyPct == bsp_pkg::DUTY_FULL) begin
      pwmOut <= 1'b1;
    end else begin
      pwmOut <= (cnt_r < highCyc);
    end
  end
endmodule // bsp_pwm_gen
`default_nettype wire

// *** hw/bsp_brake_seq.sv ***
// Brake sequencer top: APB registers, power sequencing, brake drive.
// Assumes the power state machine asks for operation enabled on a level.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module bsp_brake_seq #(
  // Cycles per delay unit; the default makes one unit a millisecond.
  parameter int TICK_CYC = bsp_pkg::MS_CYCLES
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Power state machine.
  input  wire logic        enableReq,
  input  wire logic        motorStill,
  output var  logic        motorCurrentOn,
  output var  logic        motionAllowed,
  output var  logic        stopRequest,
  // Brake open-drain pin: pulls low to energize the coil.
  input  wire logic        brakePinIn,
  output var  logic        brakePinOut,
  output var  logic        brakePinOe
);
  logic [31:0] submode_r;
  logic [31:0] outWord_r;
  logic [31:0] delay_r [4];
  logic [31:0] freq_r;
  logic [6:0]  duty_r;
  logic        badSet_r;
  logic [31:0] cnt_r;
  logic [2:0]  pinSync_r;
  logic        pinLvl_r;
  bsp_pkg::bsp_state_type state_r;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic        autoMode;
  logic        release_w;
  logic        pwmWave;
  logic [31:0] rdVal;

  // A tick below one cycle cannot scale the delay settings.
  if (TICK_CYC < 1) begin : g_tickCheck
    $error("Delay tick must be at least one cycle.");
  end

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign autoMode = submode_r[bsp_pkg::SUBMODE_BRAKE];

  // Address decode; zero-wait slave with error on unmapped words.
  always_comb begin
    mapped = 1'b1;
    rdVal  = 32'h0;
    if (paddr == bsp_pkg::ADDR_SUBMODE) begin
      rdVal = submode_r;
    end else if (paddr == bsp_pkg::ADDR_OUTWORD) begin
      rdVal = outWord_r;
    end else if (paddr == bsp_pkg::ADDR_DELAY1) begin
      rdVal = delay_r[0];
    end else if (paddr == bsp_pkg::ADDR_DELAY2) begin
      rdVal = delay_r[1];
    end else if (paddr == bsp_pkg::ADDR_DELAY3) begin
      rdVal = delay_r[2];
    end else if (paddr == bsp_pkg::ADDR_DELAY4) begin
      rdVal = delay_r[3];
    end else if (paddr == bsp_pkg::ADDR_PWMFREQ) begin
      rdVal = freq_r;
    end else if (paddr == bsp_pkg::ADDR_PWMDUTY) begin
      rdVal = {25'h0, duty_r};
    end else if (paddr == bsp_pkg::ADDR_STATUS) begin
      rdVal = {24'h0, badSet_r, pinLvl_r, motionAllowed,
               motorCurrentOn, 1'b0, 3'(state_r)};
    end else if (paddr == bsp_pkg::ADDR_CONTROL) begin
      rdVal = 32'h0;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rdVal : 32'h0;
    end
  end

  // Configuration writes; bad frequency or duty values are refused.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      submode_r <= 32'h0;
      outWord_r <= 32'h0;
      delay_r   <= '{default: 32'h0};
      freq_r    <= bsp_pkg::FREQ_RESET;
      duty_r    <= bsp_pkg::DUTY_RESET;
      badSet_r  <= 1'b0;
    end else if (wr && pready) begin
      if (paddr == bsp_pkg::ADDR_SUBMODE) begin
        submode_r <= pwdata;
      end else if (paddr == bsp_pkg::ADDR_OUTWORD) begin
        outWord_r <= pwdata;
      end else if (paddr == bsp_pkg::ADDR_DELAY1) begin
        delay_r[0] <= pwdata;
      end else if (paddr == bsp_pkg::ADDR_DELAY2) begin
        delay_r[1] <= pwdata;
      end else if (paddr == bsp_pkg::ADDR_DELAY3) begin
        delay_r[2] <= pwdata;
      end else if (paddr == bsp_pkg::ADDR_DELAY4) begin
        delay_r[3] <= pwdata;
      end else if (paddr == bsp_pkg::ADDR_PWMFREQ) begin
        if (pwdata == 32'h0 || pwdata > bsp_pkg::FREQ_MAX) begin
          badSet_r <= 1'b1;
        end else begin
          freq_r <= pwdata;
        end
      end else if (paddr == bsp_pkg::ADDR_PWMDUTY) begin
        if (pwdata < 32'(bsp_pkg::DUTY_MIN) ||
            pwdata > 32'(bsp_pkg::DUTY_FULL)) begin
          badSet_r <= 1'b1;
        end else begin
          duty_r <= pwdata[6:0];
        end
      end else if (paddr == bsp_pkg::ADDR_CONTROL) begin
        if (pwdata[0]) begin
          badSet_r <= 1'b0;
        end
      end
    end
  end

  // Delays are written in milliseconds; a value of zero skips the wait.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= bsp_pkg::ST_OFF;
      cnt_r   <= 32'h0;
    end else begin
      case (state_r)
        bsp_pkg::ST_OFF: begin
          if (enableReq) begin
            state_r <= bsp_pkg::ST_ON_WAIT3;
            cnt_r   <= delay_r[2] * 32'(TICK_CYC);
          end
        end
        bsp_pkg::ST_ON_WAIT3: begin
          if (cnt_r == 32'h0) begin
            state_r <= bsp_pkg::ST_ON_WAIT4;
            cnt_r   <= delay_r[3] * 32'(TICK_CYC);
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        bsp_pkg::ST_ON_WAIT4: begin
          if (cnt_r == 32'h0) begin
            state_r <= bsp_pkg::ST_ENABLED;
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        bsp_pkg::ST_ENABLED: begin
          if (!enableReq && motorStill) begin
            state_r <= bsp_pkg::ST_OFF_WAIT1;
            cnt_r   <= delay_r[0] * 32'(TICK_CYC);
          end
        end
        bsp_pkg::ST_OFF_WAIT1: begin
          if (cnt_r == 32'h0) begin
            state_r <= bsp_pkg::ST_OFF_WAIT2;
            cnt_r   <= delay_r[1] * 32'(TICK_CYC);
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        default: begin
          if (cnt_r == 32'h0) begin
            state_r <= bsp_pkg::ST_OFF;
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
      endcase
    end
  end

  // With autoMode set, the brake stays released through wait 4, the enabled state and off wait 1 only; otherwise it follows the output word's brake bit.
  assign release_w = autoMode ?
    (state_r == bsp_pkg::ST_ON_WAIT4 || state_r == bsp_pkg::ST_ENABLED ||
     state_r == bsp_pkg::ST_OFF_WAIT1) :
    outWord_r[bsp_pkg::OUT_BRAKE_BIT];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      motorCurrentOn <= 1'b0;
      motionAllowed  <= 1'b0;
      stopRequest    <= 1'b0;
    end else begin
      motorCurrentOn <= state_r != bsp_pkg::ST_OFF;
      motionAllowed  <= state_r == bsp_pkg::ST_ENABLED && enableReq;
      stopRequest    <= state_r == bsp_pkg::ST_ENABLED && !enableReq;
    end
  end

  bsp_pwm_gen u_pwm (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .enable  (release_w),
    .freqHz  (freq_r),
    .dutyPct (duty_r),
    .pwmOut  (pwmWave)
  );

  // Open drain: output low and enabled while the PWM is high.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      brakePinOut <= 1'b0;
      brakePinOe  <= 1'b0;
      pinSync_r   <= 3'h7;
    end else begin
      brakePinOut <= 1'b0;
      brakePinOe  <= pwmWave;
      pinSync_r   <= {pinSync_r[1:0], brakePinIn};
    end
  end

  // The pin idles high on its pull-up, so the reading starts high too.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pinLvl_r <= 1'b1;
    end else if (pinSync_r[2] == pinSync_r[1]) begin
      pinLvl_r <= pinSync_r[2];
    end
  end

  chk_brake_engaged_off: assert property (@(posedge sys_clk) disable iff
    (!resetn) autoMode && state_r == bsp_pkg::ST_OFF && $past(autoMode)
    && $past(state_r) == bsp_pkg::ST_OFF |-> ##2 !brakePinOe)
    else $error("Brake released while off.");
  chk_manual_follow: assert property (@(posedge sys_clk) disable iff
    (!resetn) !autoMode && !outWord_r[0] ##1 !autoMode && !outWord_r[0]
    |-> ##2 !brakePinOe)
    else $error("Manual brake bit ignored.");
  chk_on_order: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_r == bsp_pkg::ST_OFF && enableReq |=> state_r ==
    bsp_pkg::ST_ON_WAIT3)
    else $error("Enable sequence did not start.");
  chk_off_order: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_r == bsp_pkg::ST_ENABLED && !enableReq && motorStill |=>
    state_r == bsp_pkg::ST_OFF_WAIT1)
    else $error("Disable sequence did not start.");
  chk_current_on: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_r == bsp_pkg::ST_ON_WAIT3 |=> motorCurrentOn)
    else $error("Current off during release wait.");
  chk_full_duty: assert property (@(posedge sys_clk) disable iff (!resetn)
    release_w && duty_r == bsp_pkg::DUTY_FULL ##1 release_w &&
    duty_r == bsp_pkg::DUTY_FULL |-> ##2 brakePinOe)
    else $error("Full duty output switched.");
  chk_freq_limit: assert property (@(posedge sys_clk) disable iff (!resetn)
    freq_r <= bsp_pkg::FREQ_MAX && freq_r != 32'h0)
    else $error("Frequency out of range.");
  chk_duty_range: assert property (@(posedge sys_clk) disable iff (!resetn)
    duty_r >= bsp_pkg::DUTY_MIN && duty_r <= bsp_pkg::DUTY_FULL)
    else $error("Duty out of range.");
  chk_count_down: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_r == bsp_pkg::ST_OFF_WAIT2 && cnt_r != 32'h0 |=>
    state_r == bsp_pkg::ST_OFF_WAIT2)
    else $error("Delay ended early.");
  cov_enable: cover property (@(posedge sys_clk) state_r ==
    bsp_pkg::ST_ON_WAIT4 ##1 state_r == bsp_pkg::ST_ENABLED);
  cov_disable: cover property (@(posedge sys_clk) state_r ==
    bsp_pkg::ST_OFF_WAIT2 ##1 state_r == bsp_pkg::ST_OFF);
  cov_manual: cover property (@(posedge sys_clk) !autoMode && brakePinOe);
endmodule // bsp_brake_seq
`default_nettype wire

// *** test/bsp_coil_model.sv ***
// Brake coil behind the open-drain brake pin, with a pull-up resistor.
// Assumes the design pulls the pin low to energize (release) the coil.
`timescale 1ns/1ps
`default_nettype none
module bsp_coil_model (
  // Clock and measurement control.
  input  wire logic sys_clk,
  input  wire logic clr,
  // Pin.
  input  wire logic brakePinOut,
  input  wire logic brakePinOe,
  output var  logic pinLevel,
  // Observation.
  output var  logic energized,
  output var  int   onCycles,
  output var  int   toggles
);
  logic lastLevel_r;
  // Nobody pulling leaves the pull-up in charge, so a free pin reads high.
  assign pinLevel = brakePinOe ? brakePinOut : 1'b1;
  assign energized = ~pinLevel;
  always_ff @(posedge sys_clk) begin
    lastLevel_r <= pinLevel;
    if (clr) begin
      onCycles <= 0;
      toggles  <= 0;
    end else begin
      onCycles <= onCycles + int'(energized);
      toggles  <= toggles + int'(lastLevel_r != pinLevel);
    end
  end
endmodule // bsp_coil_model
`default_nettype wire

// *** test/brake_sequencer_pwm_bench.sv ***
// Self-checking bench for the brake sequencer with PWM brake drive.
// Assumes a ten-cycle delay tick so the sequencing waits stay short.
`timescale 1ns/1ps
`default_nettype none
module brake_sequencer_pwm_bench;
  typedef struct {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic        bad;
  } bsp_row_type;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic        enableReq  = 1'b0;
  logic        motorStill = 1'b0;
  logic        clr        = 1'b1;
  logic [31:0] prdata, rd;
  localparam int TICK_CYC = 10;
  logic        pready, pslverr, err, rdy, motorCurrentOn, motionAllowed;
  logic        stopRequest, brakePinOut, brakePinOe, pinLevel, energized;
  int          onCycles, toggles, numErrors, samplesChecked, i, tA, tB, tC;
  bsp_row_type rows[11] = '{
    '{bsp_pkg::ADDR_DELAY1, 32'h0000_0002, 32'h0000_0002, 1'b0},
    '{bsp_pkg::ADDR_DELAY2, 32'h0000_0003, 32'h0000_0003, 1'b0},
    '{bsp_pkg::ADDR_DELAY3, 32'h0000_0003, 32'h0000_0003, 1'b0},
    '{bsp_pkg::ADDR_DELAY4, 32'h0000_0004, 32'h0000_0004, 1'b0},
    '{bsp_pkg::ADDR_PWMFREQ, 32'h0000_4e20, 32'h0000_4e20, 1'b0},
    '{bsp_pkg::ADDR_PWMFREQ, 32'h0000_4e21, 32'h0000_4e20, 1'b1},
    '{bsp_pkg::ADDR_PWMFREQ, 32'h0000_0000, 32'h0000_4e20, 1'b1},
    '{bsp_pkg::ADDR_PWMDUTY, 32'h0000_0002, 32'h0000_0002, 1'b0},
    '{bsp_pkg::ADDR_PWMDUTY, 32'h0000_0001, 32'h0000_0002, 1'b1},
    '{bsp_pkg::ADDR_PWMDUTY, 32'h0000_0065, 32'h0000_0002, 1'b1},
    '{bsp_pkg::ADDR_PWMDUTY, 32'h0000_0032, 32'h0000_0032, 1'b0}};
  always #5 sys_clk = ~sys_clk;
  bsp_brake_seq #(.TICK_CYC(TICK_CYC)) bsp_brake_seq_i (.sys_clk(sys_clk),
    .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enableReq(enableReq), .motorStill(motorStill),
    .motorCurrentOn(motorCurrentOn), .motionAllowed(motionAllowed),
    .stopRequest(stopRequest), .brakePinIn(pinLevel),
    .brakePinOut(brakePinOut), .brakePinOe(brakePinOe));
  bsp_coil_model bsp_coil_model_i (.sys_clk(sys_clk), .clr(clr),
    .brakePinOut(brakePinOut), .brakePinOe(brakePinOe),
    .pinLevel(pinLevel), .energized(energized), .onCycles(onCycles),
    .toggles(toggles));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      numErrors++;
    end
  endtask
  // Holds the request until pready is sampled high, as APB requires.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    #1;
    while (pready !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    // The answer is registered, so what stands now is what the edge samples.
    rdy = pready;
    rd = prdata;
    err = pslverr;
    @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, {31'h0, rdy});
  endtask
  // Measures one PWM period of 5000 cycles at 20000 Hz.
  task automatic measure(input int on, input int tg);
    repeat (100) @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (5000) @(posedge sys_clk);
    #1;
    chk("onCycles", 32'(on), 32'(onCycles));
    chk("toggles", 32'(tg), 32'(toggles));
  endtask
  // Records the first cycle at which current, coil and motion match lvl.
  task automatic trace(input logic lvl);
    tA = 0;
    tB = 0;
    tC = 0;
    for (i = 1; i <= 300; i++) begin
      @(posedge sys_clk);
      #1;
      if (tA == 0 && motorCurrentOn === lvl) tA = i;
      if (tB == 0 && energized === lvl) tB = i;
      if (tC == 0 && motionAllowed === lvl) tC = i;
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    chk("resetOut", 32'h0, {27'h0, motorCurrentOn, motionAllowed,
        stopRequest, brakePinOe, pready});
    resetn <= 1'b1;
    apb(1'b0, bsp_pkg::ADDR_PWMFREQ, 32'h0);
    chk("freqReset", bsp_pkg::FREQ_RESET, rd);
    apb(1'b0, bsp_pkg::ADDR_PWMDUTY, 32'h0);
    chk("dutyReset", {25'h0, bsp_pkg::DUTY_RESET}, rd);
    $display("Test reset done");
    foreach (rows[k]) begin
      apb(1'b1, rows[k].a, rows[k].d);
      apb(1'b0, rows[k].a, 32'h0);
      chk("readBack", rows[k].r, rd);
      apb(1'b0, bsp_pkg::ADDR_STATUS, 32'h0);
      chk("badFlag", {31'h0, rows[k].bad}, {31'h0, rd[7]});
      apb(1'b1, bsp_pkg::ADDR_CONTROL, 32'h1);
      chk("ctrlMapped", 32'h0, {31'h0, err});
    end
    apb(1'b0, 12'h03c, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("Test settings done");
    apb(1'b1, bsp_pkg::ADDR_OUTWORD, 32'h1);
    measure(2500, 2);
    apb(1'b1, bsp_pkg::ADDR_PWMDUTY, 32'h64);
    measure(5000, 0);
    apb(1'b0, bsp_pkg::ADDR_STATUS, 32'h0);
    chk("pinLow", 32'h0, {31'h0, rd[6]});
    apb(1'b1, bsp_pkg::ADDR_OUTWORD, 32'h2);
    repeat (10) @(posedge sys_clk);
    chk("otherBit", 32'h0, {31'h0, energized});
    apb(1'b0, bsp_pkg::ADDR_STATUS, 32'h0);
    chk("pinHigh", 32'h1, {31'h0, rd[6]});
    $display("Test manual done");
    apb(1'b1, bsp_pkg::ADDR_SUBMODE, 32'h4);
    apb(1'b1, bsp_pkg::ADDR_OUTWORD, 32'h1);
    repeat (10) @(posedge sys_clk);
    chk("autoIdle", 32'h0, {31'h0, energized});
    @(posedge sys_clk);
    enableReq <= 1'b1;
    trace(1'b1);
    chk("curBeforeBrake", 32'h1, {31'h0, tA > 0 && tA < tB});
    chk("motionSeen", 32'h1, {31'h0, tC > 0 && tA < tC});
    chk("onDelay", 32'(3 * TICK_CYC + 2), 32'(tB - tA));
    chk("runDelay", 32'(4 * TICK_CYC), 32'(tC - tB));
    $display("Test enable done");
    @(posedge sys_clk);
    enableReq <= 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
    chk("stopping", 32'h6, {29'h0, stopRequest, energized,
        motionAllowed});
    @(posedge sys_clk);
    motorStill <= 1'b1;
    trace(1'b0);
    chk("brakeBeforeOff", 32'h1, {31'h0, tB > 0 && tB < tA});
    chk("stopDelay", 32'(2 * TICK_CYC + 4), 32'(tB));
    chk("offDelay", 32'(3 * TICK_CYC), 32'(tA - tB));
    $display("Test disable done");
    print_verdict();
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    numErrors++;
    print_verdict();
  end
endmodule // brake_sequencer_pwm_bench
`default_nettype wire
